// ===== verif/aosw_host_model.sv
`timescale 1ns/1ps
// Host processor: owns the core supply and watches the interrupt wire
module aosw_host_model (
	input wire logic clock,
	input wire logic irq_wire,
	input wire logic sleep_req,
	input wire logic wake_req,
	output logic core_supply,
	output logic irq_seen
);
	// Supply starts present so the block wakes after reset
	initial core_supply = 1'b1;
	initial irq_seen = 1'b0;

	// Supply control; wake only on an interrupt that was seen
	always @(posedge clock) begin
		irq_seen <= !irq_wire;
		if (sleep_req) begin
			core_supply <= 1'b0;
		end else if (wake_req && irq_seen) begin
			core_supply <= 1'b1;
		end
	end
endmodule

// ===== verif/tb_aosw_top.sv
`timescale 1ns/1ps
module tb_aosw_top;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic jack_a = 1'b0;
	logic jack_b = 1'b0;
	logic rst_n = 1'b1;
	logic [aosw_pkg::CORE_W-1:0] din = 8'h5A;
	logic [15:0] awaddr = 16'h0000;
	logic [15:0] araddr = 16'h0000;
	logic [31:0] wdata = 32'h00000000;
	logic awv = 1'b0;
	logic wv = 1'b0;
	logic arv = 1'b0;
	logic bready = 1'b0;
	logic rready = 1'b0;
	logic sleep_req = 1'b0;
	logic wake_req = 1'b0;
	logic supply, oe_n, keeper, pu, pd, clamp, irq, irq_o, irq_oe_n, irq_seen;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [aosw_pkg::CORE_W-1:0] dout;
	int bad_count = 0;
	int num_checks = 0;
	// Interrupt wire has a pull-up when released
	wire irq_wire = irq_oe_n ? 1'b1 : irq_o;

	// 200 MHz clock
	initial begin
		forever #2.5 clock = ~clock;
	end

	aosw_top u_aosw_top (.CLOCK(clock), .SYS_RST(sys_rst), .CORE_SUPPLY(supply),
		.JACK_SENSE_IN_A(jack_a), .JACK_SENSE_IN_B(jack_b), .RESET_PIN_N(rst_n),
		.CORE_DIN(din), .CORE_DOUT(dout), .CORE_DOUT_OE_N(oe_n), .KEEPER_EN(keeper),
		.RESET_PIN_PULLUP(pu), .RESET_PIN_PULLDOWN(pd), .CLAMP_STATUS(clamp), .IRQ(irq),
		.IRQ_PIN_O(irq_o), .IRQ_PIN_OE_N(irq_oe_n), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready));

	aosw_host_model u_aosw_host_model (.clock(clock), .irq_wire(irq_wire),
		.sleep_req(sleep_req), .wake_req(wake_req), .core_supply(supply),
		.irq_seen(irq_seen));

	// Verdict and end of run
	task automatic stop_test;
		if (bad_count == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Compare after the edge's updates have landed
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		#1;
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, g, e);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	// Bus write; address and data offered together, each dropped when taken
	task automatic wr(input logic [13:0] idx, input logic [31:0] d, input logic [1:0] er);
		int n = 0;
		logic ok = 1'b0;
		logic [1:0] r = 2'h0;
		logic aw_t = 1'b0;
		logic w_t = 1'b0;
		logic b_t = 1'b0;
		@(posedge clock);
		awaddr <= {idx, 2'b00};
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		// Handshakes judged mid-cycle, where they are settled for the coming edge
		while (!ok && n < 100) begin
			@(negedge clock);
			aw_t = awv & awready;
			w_t = wv & wready;
			b_t = bvalid;
			r = bresp;
			@(posedge clock);
			n++;
			if (aw_t) begin
				awv <= 1'b0;
			end
			if (w_t) begin
				wv <= 1'b0;
			end
			if (b_t) begin
				ok = 1'b1;
			end
		end
		bready <= 1'b0;
		chk({29'h0, ok, r}, {29'h0, 1'b1, er});
	endtask

	// Bus read; data checked only when an OKAY answer is expected
	task automatic rd(input logic [13:0] idx, input logic [31:0] e, input logic [1:0] er);
		int n = 0;
		logic ok = 1'b0;
		logic [1:0] r = 2'h0;
		logic [31:0] d = 32'h0;
		logic ar_t = 1'b0;
		logic r_t = 1'b0;
		@(posedge clock);
		araddr <= {idx, 2'b00};
		arv <= 1'b1;
		rready <= 1'b1;
		// Answer taken at the edge where rvalid and rready meet
		while (!ok && n < 100) begin
			@(negedge clock);
			ar_t = arv & arready;
			r_t = rvalid;
			r = rresp;
			d = rdata;
			@(posedge clock);
			n++;
			if (ar_t) begin
				arv <= 1'b0;
			end
			if (r_t) begin
				ok = 1'b1;
			end
		end
		rready <= 1'b0;
		chk({29'h0, ok, r}, {29'h0, 1'b1, er});
		if (er === aosw_pkg::RESP_OKAY) chk(d, e);
	endtask

	// Hang guard, well beyond the sequence's length
	initial begin
		#40000;
		bad_count++;
		stop_test;
	end

	// Main sequence
	initial begin
		tick(10);
		sys_rst <= 1'b0;
		tick(4);
		rd(aosw_pkg::IDX_MASKS, 32'h3F, aosw_pkg::RESP_OKAY);
		rd(aosw_pkg::IDX_RST_PULLS, 32'h1, aosw_pkg::RESP_OKAY);
		rd(aosw_pkg::IDX_JACK_EN, 32'h0, aosw_pkg::RESP_OKAY);
		rd(aosw_pkg::IDX_CLAMP_CFG, 32'h0, aosw_pkg::RESP_OKAY);
		rd(14'h03FF, 32'h0, aosw_pkg::RESP_DECERR);
		rd(aosw_pkg::IDX_STATUS, 32'h5A, aosw_pkg::RESP_OKAY);
		wr(aosw_pkg::IDX_RST_PULLS, 32'h2, aosw_pkg::RESP_OKAY);
		chk({pd, pu}, 32'h2);
		// Clamp high only when both detects are high
		wr(aosw_pkg::IDX_CLAMP_CFG, 32'h8, aosw_pkg::RESP_OKAY);
		wr(aosw_pkg::IDX_JACK_EN, 32'h3, aosw_pkg::RESP_OKAY);
		wr(aosw_pkg::IDX_MASKS, 32'h0, aosw_pkg::RESP_OKAY);
		wr(aosw_pkg::IDX_IRQ_CFG, 32'h0, aosw_pkg::RESP_OKAY);
		wr(aosw_pkg::IDX_CORE_OUT, 32'h1AB, aosw_pkg::RESP_OKAY);
		chk({oe_n, keeper, dout}, {1'b0, 1'b1, 8'hAB});
		jack_a <= 1'b1;
		tick(6);
		jack_b <= 1'b1;
		tick(6);
		chk({clamp, irq, irq_wire}, 32'h6);
		rd(aosw_pkg::IDX_FLAGS, 32'h15, aosw_pkg::RESP_OKAY);
		rd(aosw_pkg::IDX_FLAGS, 32'h0, aosw_pkg::RESP_OKAY);
		chk(irq_wire, 1'b1);
		// Reset pin clears the core register only
		rst_n <= 1'b0;
		tick(3);
		rst_n <= 1'b1;
		tick(2);
		rd(aosw_pkg::IDX_CORE_OUT, 32'h0, aosw_pkg::RESP_OKAY);
		rd(aosw_pkg::IDX_JACK_EN, 32'h3, aosw_pkg::RESP_OKAY);
		wr(aosw_pkg::IDX_CORE_OUT, 32'h1AB, aosw_pkg::RESP_OKAY);
		// Bus is idle; the host removes the supply
		sleep_req <= 1'b1;
		tick(1);
		sleep_req <= 1'b0;
		tick(4);
		chk({supply, oe_n, keeper, irq_wire}, 32'h5);
		rd(aosw_pkg::IDX_JACK_EN, 32'h0, aosw_pkg::RESP_SLVERR);
		jack_a <= 1'b0;
		din <= 8'h00;
		tick(8);
		chk(irq_wire, 1'b0);
		tick(20);
		chk({supply, irq_wire}, 32'h0);
		wake_req <= 1'b1;
		tick(1);
		wake_req <= 1'b0;
		tick(6);
		rd(aosw_pkg::IDX_JACK_EN, 32'h3, aosw_pkg::RESP_OKAY);
		rd(aosw_pkg::IDX_MASKS, 32'h0, aosw_pkg::RESP_OKAY);
		rd(aosw_pkg::IDX_CLAMP_CFG, 32'h8, aosw_pkg::RESP_OKAY);
		rd(aosw_pkg::IDX_RST_PULLS, 32'h2, aosw_pkg::RESP_OKAY);
		rd(aosw_pkg::IDX_CORE_OUT, 32'h0, aosw_pkg::RESP_OKAY);
		rd(aosw_pkg::IDX_FLAGS, 32'h22, aosw_pkg::RESP_OKAY);
		chk(irq_wire, 1'b1);
		// Masked event, then unmasked, polarity and line mask
		wr(aosw_pkg::IDX_MASKS, 32'h3F, aosw_pkg::RESP_OKAY);
		jack_b <= 1'b0;
		tick(6);
		chk(irq, 1'b0);
		wr(aosw_pkg::IDX_MASKS, 32'h0, aosw_pkg::RESP_OKAY);
		chk({irq, irq_wire}, 32'h2);
		wr(aosw_pkg::IDX_IRQ_CFG, 32'h2, aosw_pkg::RESP_OKAY);
		chk(irq_o, 1'b1);
		wr(aosw_pkg::IDX_IRQ_CFG, 32'h1, aosw_pkg::RESP_OKAY);
		chk(irq, 1'b0);
		rd(aosw_pkg::IDX_FLAGS, 32'h8, aosw_pkg::RESP_OKAY);
		stop_test;
	end
endmodule

// ===== verilog/aosw_pkg.sv
package aosw_pkg;
	// Register indexes; byte address is four times the index
	localparam logic [13:0] IDX_CLAMP_CFG = 14'h02C6;
	localparam logic [13:0] IDX_JACK_EN = 14'h02D3;
	localparam logic [13:0] IDX_FLAGS = 14'h1806;
	localparam logic [13:0] IDX_MASKS = 14'h1846;
	localparam logic [13:0] IDX_IRQ_CFG = 14'h1A80;
	localparam logic [13:0] IDX_RST_PULLS = 14'h1AD0;
	localparam logic [13:0] IDX_CORE_OUT = 14'h0010;
	localparam logic [13:0] IDX_STATUS = 14'h0011;
	localparam int ADDR_W = 16;
	localparam int CORE_W = 8;
	// Field positions
	localparam int F_CLAMP_OVR = 4;
	localparam int F_EN_A = 0;
	localparam int F_EN_B = 1;
	localparam int F_LINE_MASK = 0;
	localparam int F_POL = 1;
	localparam int F_OPEN_DRAIN = 2;
	localparam int F_PULLUP = 0;
	localparam int F_PULLDOWN = 1;
	localparam int F_OUT_EN = 8;
	// Flag bit order: a rise, a fall, b rise, b fall, clamp rise, clamp fall
	localparam int NFLAG = 6;
	// Reset values
	localparam logic [15:0] RST_CLAMP_CFG = 16'h0000;
	localparam logic [1:0] RST_JACK_EN = 2'h0;
	localparam logic [NFLAG-1:0] RST_MASKS = 6'h3F;
	localparam logic [2:0] RST_IRQ_CFG = 3'h0;
	localparam logic [1:0] RST_PULLS = 2'h1;
	localparam logic [15:0] RST_CORE_OUT = 16'h0000;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// Power states
	typedef enum logic [1:0] {
		PWR_AWAKE = 2'b00,
		PWR_ASLEEP = 2'b01,
		PWR_WAKING = 2'b10
	} aosw_pwr_e;
	// Whole module state
	typedef struct packed {
		aosw_pwr_e pwr;
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [15:0] clamp_cfg;
		logic [1:0] jack_en;
		logic [NFLAG-1:0] flags;
		logic [NFLAG-1:0] masks;
		logic [2:0] irq_cfg;
		logic [1:0] pulls;
		logic [15:0] core_out;
		logic [CORE_W-1:0] core_in;
		logic jd_a;
		logic jd_b;
		logic clamp;
		logic prev_a;
		logic prev_b;
		logic prev_clamp;
		logic irq_hold;
	} aosw_state_s;
endpackage

// ===== verilog/aosw_top.sv
`timescale 1ns/1ps
module aosw_top (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic CORE_SUPPLY,
	input wire logic JACK_SENSE_IN_A,
	input wire logic JACK_SENSE_IN_B,
	input wire logic RESET_PIN_N,
	input wire logic [aosw_pkg::CORE_W-1:0] CORE_DIN,
	output logic [aosw_pkg::CORE_W-1:0] CORE_DOUT,
	output logic CORE_DOUT_OE_N,
	output logic KEEPER_EN,
	output logic RESET_PIN_PULLUP,
	output logic RESET_PIN_PULLDOWN,
	output logic CLAMP_STATUS,
	output logic IRQ,
	output logic IRQ_PIN_O,
	output logic IRQ_PIN_OE_N,
	input wire logic [aosw_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [aosw_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] be);
		merge16 = old;
		if (be[0]) begin
			merge16[7:0] = d[7:0];
		end
		if (be[1]) begin
			merge16[15:8] = d[15:8];
		end
	endfunction

	// Address to register index, word aligned
	function automatic logic [13:0] reg_index(input logic [aosw_pkg::ADDR_W-1:0] a);
		reg_index = a[aosw_pkg::ADDR_W-1:2];
	endfunction

	// Clamp select is a truth table over {detect b, detect a}
	function automatic logic clamp_fn(input logic [3:0] sel, input logic a, input logic b);
		clamp_fn = sel[{b, a}];
	endfunction

	// Current and next state
	aosw_pkg::aosw_state_s s;
	aosw_pkg::aosw_state_s next_s;
	// Bus handshakes
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	// Asleep or leaving sleep; both keep the core quiet
	logic core_off;
	// Combined interrupt condition
	logic irq_req;
	// Logical assertion of the interrupt pin
	logic pin_act;
	// Edge events this cycle
	logic [aosw_pkg::NFLAG-1:0] events;
	// Read mux result
	logic [31:0] rd_word;
	logic [1:0] rd_resp;
	// Flags cleared by the read taken this cycle
	logic flag_rd;

	assign core_off = (s.pwr != aosw_pkg::PWR_AWAKE);
	// Handshake outputs are combinational; one write and one read at a time
	assign S_AXI_AWREADY = ~s.aw_got & ~s.bvalid;
	assign S_AXI_WREADY = ~s.w_got & ~s.bvalid;
	assign S_AXI_ARREADY = ~s.rvalid;
	assign aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
	assign w_hs = S_AXI_WVALID & S_AXI_WREADY;
	assign ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
	assign S_AXI_BVALID = s.bvalid;
	assign S_AXI_BRESP = s.bresp;
	assign S_AXI_RVALID = s.rvalid;
	assign S_AXI_RDATA = s.rdata;
	assign S_AXI_RRESP = s.rresp;

	// Edge events from the registered detects and clamp
	assign events = {~s.clamp & s.prev_clamp, s.clamp & ~s.prev_clamp,
		~s.jd_b & s.prev_b, s.jd_b & ~s.prev_b,
		~s.jd_a & s.prev_a, s.jd_a & ~s.prev_a};

	// Unmasked flags reach the line unless the line itself is masked
	assign irq_req = (|(s.flags & ~s.masks)) & ~s.irq_cfg[aosw_pkg::F_LINE_MASK];
	assign IRQ = irq_req;
	// Only jack-derived flags exist here, so sleep assertion has no other cause
	assign pin_act = irq_req | s.irq_hold;

	// Interrupt pin: polarity then drive style
	always_comb begin
		IRQ_PIN_O = s.irq_cfg[aosw_pkg::F_POL] ? pin_act : ~pin_act;
		// Open drain only pulls low, never drives high
		if (s.irq_cfg[aosw_pkg::F_OPEN_DRAIN]) begin
			IRQ_PIN_OE_N = IRQ_PIN_O;
		end else begin
			IRQ_PIN_OE_N = 1'b0;
		end
	end

	// Core outputs float and keepers drop while the core is off
	assign CORE_DOUT = s.core_out[aosw_pkg::CORE_W-1:0];
	assign CORE_DOUT_OE_N = core_off | ~s.core_out[aosw_pkg::F_OUT_EN];
	assign KEEPER_EN = ~core_off;
	// Reset pin pulls come from always-on storage
	assign RESET_PIN_PULLUP = s.pulls[aosw_pkg::F_PULLUP];
	assign RESET_PIN_PULLDOWN = s.pulls[aosw_pkg::F_PULLDOWN];
	assign CLAMP_STATUS = s.clamp;

	// Read mux; refused while the core is off
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_resp = aosw_pkg::RESP_OKAY;
		flag_rd = 1'b0;
		if (core_off) begin
			rd_resp = aosw_pkg::RESP_SLVERR;
		end else begin
			case (reg_index(S_AXI_ARADDR))
				aosw_pkg::IDX_CLAMP_CFG: rd_word[15:0] = s.clamp_cfg;
				aosw_pkg::IDX_JACK_EN: rd_word[1:0] = s.jack_en;
				aosw_pkg::IDX_FLAGS: begin
					rd_word[aosw_pkg::NFLAG-1:0] = s.flags;
					flag_rd = ar_hs;
				end
				aosw_pkg::IDX_MASKS: rd_word[aosw_pkg::NFLAG-1:0] = s.masks;
				aosw_pkg::IDX_IRQ_CFG: rd_word[2:0] = s.irq_cfg;
				aosw_pkg::IDX_RST_PULLS: rd_word[1:0] = s.pulls;
				aosw_pkg::IDX_CORE_OUT: rd_word[15:0] = s.core_out;
				// Status: sampled core inputs, detects, clamp, interrupt
				aosw_pkg::IDX_STATUS: rd_word[11:0] = {irq_req, s.clamp, s.jd_b, s.jd_a,
					s.core_in};
				default: rd_resp = aosw_pkg::RESP_DECERR;
			endcase
		end
	end

	// Next-state logic
	always_comb begin
		next_s = s;
		// Power sequencing follows the supply alone
		case (s.pwr)
			aosw_pkg::PWR_AWAKE: begin
				if (!CORE_SUPPLY) begin
					next_s.pwr = aosw_pkg::PWR_ASLEEP;
				end
			end
			aosw_pkg::PWR_ASLEEP: begin
				// Jack activity never leaves sleep by itself
				if (CORE_SUPPLY) begin
					next_s.pwr = aosw_pkg::PWR_WAKING;
				end
			end
			aosw_pkg::PWR_WAKING: begin
				next_s.pwr = CORE_SUPPLY ? aosw_pkg::PWR_AWAKE : aosw_pkg::PWR_ASLEEP;
			end
			default: next_s.pwr = aosw_pkg::PWR_ASLEEP;
		endcase

		// Jack detects follow their pins when enabled, also in sleep
		next_s.jd_a = s.jack_en[aosw_pkg::F_EN_A] & JACK_SENSE_IN_A;
		next_s.jd_b = s.jack_en[aosw_pkg::F_EN_B] & JACK_SENSE_IN_B;
		// Override forces the clamp active regardless of the detects
		next_s.clamp = s.clamp_cfg[aosw_pkg::F_CLAMP_OVR] |
			clamp_fn(s.clamp_cfg[3:0], s.jd_a, s.jd_b);
		next_s.prev_a = s.jd_a;
		next_s.prev_b = s.jd_b;
		next_s.prev_clamp = s.clamp;

		// Sticky flags; a new event wins over clear-on-read
		if (flag_rd) begin
			next_s.flags = events;
		end else begin
			next_s.flags = s.flags | events;
		end

		// Once asserted in sleep the line stays until a wake-up
		if (s.pwr == aosw_pkg::PWR_WAKING) begin
			next_s.irq_hold = 1'b0;
		end else if (s.pwr == aosw_pkg::PWR_ASLEEP) begin
			next_s.irq_hold = s.irq_hold | irq_req;
		end

		// Core inputs are only looked at while awake
		if (!core_off) begin
			next_s.core_in = CORE_DIN;
		end

		// Write address and data may come in either order
		if (aw_hs) begin
			next_s.aw_got = 1'b1;
			next_s.awaddr = S_AXI_AWADDR;
		end
		if (w_hs) begin
			next_s.wdata = S_AXI_WDATA;
			next_s.wstrb = S_AXI_WSTRB;
			next_s.w_got = 1'b1;
		end
		// Commit once both halves are held
		if (s.aw_got && s.w_got) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = aosw_pkg::RESP_OKAY;
			if (core_off) begin
				// Access port is dead in sleep; nothing is stored
				next_s.bresp = aosw_pkg::RESP_SLVERR;
			end else begin
				case (reg_index(s.awaddr))
					aosw_pkg::IDX_CLAMP_CFG: begin
						next_s.clamp_cfg = merge16(s.clamp_cfg, s.wdata, s.wstrb) &
							16'h001F;
					end
					aosw_pkg::IDX_JACK_EN: begin
						if (s.wstrb[0]) begin
							next_s.jack_en = s.wdata[1:0];
						end
					end
					// Flags only clear by reading; writes are dropped
					aosw_pkg::IDX_FLAGS: next_s.bresp = aosw_pkg::RESP_OKAY;
					aosw_pkg::IDX_MASKS: begin
						if (s.wstrb[0]) begin
							next_s.masks = s.wdata[aosw_pkg::NFLAG-1:0];
						end
					end
					aosw_pkg::IDX_IRQ_CFG: begin
						if (s.wstrb[0]) begin
							next_s.irq_cfg = s.wdata[2:0];
						end
					end
					aosw_pkg::IDX_RST_PULLS: begin
						if (s.wstrb[0]) begin
							next_s.pulls = s.wdata[1:0];
						end
					end
					aosw_pkg::IDX_CORE_OUT: begin
						next_s.core_out = merge16(s.core_out, s.wdata, s.wstrb) & 16'h01FF;
					end
					aosw_pkg::IDX_STATUS: next_s.bresp = aosw_pkg::RESP_OKAY;
					default: next_s.bresp = aosw_pkg::RESP_DECERR;
				endcase
			end
		end
		if (s.bvalid && S_AXI_BREADY) begin
			next_s.bvalid = 1'b0;
		end

		// Read answer one cycle after the address is taken
		if (ar_hs) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = rd_word;
			next_s.rresp = rd_resp;
		end else if (s.rvalid && S_AXI_RREADY) begin
			next_s.rvalid = 1'b0;
		end

		// Core registers return to defaults on wake or reset pin; always-on stay
		if (s.pwr == aosw_pkg::PWR_WAKING || !RESET_PIN_N) begin
			next_s.core_out = aosw_pkg::RST_CORE_OUT;
			next_s.core_in = '0;
		end
	end

	// State register; only the system reset touches always-on fields
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			s <= '{pwr: aosw_pkg::PWR_ASLEEP, clamp_cfg: aosw_pkg::RST_CLAMP_CFG,
				jack_en: aosw_pkg::RST_JACK_EN, masks: aosw_pkg::RST_MASKS,
				irq_cfg: aosw_pkg::RST_IRQ_CFG, pulls: aosw_pkg::RST_PULLS,
				core_out: aosw_pkg::RST_CORE_OUT, default: '0};
		end else begin
			s <= next_s;
		end
	end

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (SYS_RST);

	a_sleep_on_supply: assert property (!CORE_SUPPLY |=> s.pwr == aosw_pkg::PWR_ASLEEP)
		else $error("supply gone but not asleep");
	a_jack_event_sleep: assert property ((s.pwr == aosw_pkg::PWR_ASLEEP && !CORE_SUPPLY &&
		$fell(s.jd_a)) |=> s.flags[1])
		else $error("jack a fall lost in sleep");
	a_retain_aon: assert property ((s.pwr == aosw_pkg::PWR_ASLEEP) |=>
		(s.clamp_cfg == $past(s.clamp_cfg) && s.masks == $past(s.masks) &&
		s.pulls == $past(s.pulls)))
		else $error("always-on register changed in sleep");
	a_bus_refused: assert property ((s.aw_got && s.w_got && core_off) |=>
		(S_AXI_BVALID && S_AXI_BRESP == aosw_pkg::RESP_SLVERR))
		else $error("write accepted while asleep");
	a_outputs_float: assert property ((s.pwr == aosw_pkg::PWR_ASLEEP) |->
		(CORE_DOUT_OE_N && !KEEPER_EN))
		else $error("core pin driven in sleep");
	a_irq_held: assert property ((s.pwr == aosw_pkg::PWR_ASLEEP && pin_act && !CORE_SUPPLY)
		|=> pin_act [*2])
		else $error("interrupt dropped before wake");
	a_detect_follow: assert property ((s.jack_en[0] && JACK_SENSE_IN_A) |=> s.jd_a)
		else $error("detect a does not follow pin");
	a_clamp_logic: assert property ((!s.clamp_cfg[4] && s.clamp_cfg[3:0] == 4'h8 &&
		s.jd_a && s.jd_b) |=> s.clamp)
		else $error("clamp and-combination wrong");
	a_rise_flag: assert property ($rose(s.jd_a) |=> s.flags[0] ##1 (s.flags[0] ||
		$past(flag_rd)))
		else $error("rise flag not set");
	a_no_self_wake: assert property ((s.pwr == aosw_pkg::PWR_ASLEEP && !CORE_SUPPLY) |=>
		s.pwr == aosw_pkg::PWR_ASLEEP)
		else $error("woke without supply");
	a_core_reset_wake: assert property ((s.pwr == aosw_pkg::PWR_WAKING) |=>
		(s.core_out == aosw_pkg::RST_CORE_OUT && !s.irq_hold))
		else $error("core state survived wake");
	a_irq_sleep_cause: assert property ((s.pwr == aosw_pkg::PWR_ASLEEP && $rose(pin_act))
		|-> $past(|events))
		else $error("sleep interrupt without jack event");
endmodule
